// ==== rtl/uefp_top.sv ====
`timescale 1ns/1ps
`include "uefp_cfg.svh"
// Summary of operation
// - Each FIFO's read offset points at the next byte to fetch and advances.
// - Each FIFO's write offset points at the next byte to fill and advances.
// - Shared RAM address combines the FIFO base port with the pointer offset.
// - Software may read and write both pointers for debug.
// - Pointer field width follows FIFO size, bit 0 lowest, upper bits reserved.
// - Pointer bits above the FIFO size are kept unchanged by writes.
// - Pointer field is at most twelve bits, up to 4096 entries.
// - A one kilobyte descriptor memory is written and read by software.
// - All endpoint FIFOs keep their data in one common RAM.
// - Software registers set each FIFO size, changeable while running.
// - One dedicated data FIFO per endpoint.
// - Transfers to any endpoint in any order, back to back allowed.
// - Data is accepted at once on request; read data is supplied one cycle after the request.
// - Last frame pointer clears at reset; bits above FIFO size untouched.
module uefp_top (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [11:0]           awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	input  wire logic [11:0]           araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic [31:0]                rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	input  wire uefp_pkg::uefp_ep_t    usb_ep,
	input  wire logic                  usb_wr_en,
	input  wire uefp_pkg::uefp_byte_t  usb_wr_data,
	input  wire logic                  usb_wr_eof,
	input  wire logic                  usb_rd_en,
	output logic [`UEFP_DATA_W-1:0]    usb_rd_data,
	output logic                       usb_rd_valid,
	input  wire uefp_pkg::uefp_ptr_t   ep_base [`UEFP_NUM_EP],
	output logic [`UEFP_NUM_EP-1:0]    ep_empty,
	output logic [`UEFP_NUM_EP-1:0]    ep_full
);
	import uefp_pkg::*;
	function automatic uefp_ptr_t merge_ptr(uefp_ptr_t old, logic [31:0] d, logic [3:0] s);
		merge_ptr = old;
		if (s[0]) begin
			merge_ptr[7:0] = d[7:0];
		end
		if (s[1]) begin
			merge_ptr[11:8] = d[11:8];
		end
	endfunction
	function automatic logic reg_known(logic [4:0] off);
		reg_known = (off == `UEFP_OFF_RP) || (off == `UEFP_OFF_WP) || (off == `UEFP_OFF_LFP)
			|| (off == `UEFP_OFF_SIZE) || (off == `UEFP_OFF_STAT);
	endfunction
	uefp_ptr_t               rp      [`UEFP_NUM_EP];
	uefp_ptr_t               wp      [`UEFP_NUM_EP];
	uefp_ptr_t               lfp     [`UEFP_NUM_EP];
	uefp_ptr_t               mask    [`UEFP_NUM_EP];
	uefp_size_t              size    [`UEFP_NUM_EP];
	logic [`UEFP_NUM_EP-1:0] full;
	logic [`UEFP_NUM_EP-1:0] empty;
	logic [`UEFP_NUM_EP-1:0] push_ok;
	logic [`UEFP_NUM_EP-1:0] pop_ok;
	logic [11:0]             aw_addr;
	logic [11:0]             rd_addr;
	logic [31:0]             wdata_q;
	logic [3:0]              wstrb_q;
	logic                    rd_pend;
	logic                    wr_fire;
	logic                    wr_ep;
	logic                    wr_desc;
	logic                    wr_ok;
	logic                    rd_ep;
	logic                    rd_desc;
	logic                    rd_ok;
	uefp_ep_t                wr_idx;
	uefp_ep_t                rd_idx;
	logic [4:0]              wr_off;
	logic [4:0]              rd_off;
	logic [31:0]             desc_rdata;
	logic [31:0]             ep_rdata;
	uefp_ptr_t               ram_waddr;
	uefp_ptr_t               ram_raddr;
	// Write address and data are held until the response is accepted
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			aw_addr <= 12'h000;
		end else if (awvalid && awready) begin
			awready <= 1'b0;
			aw_addr <= awaddr;
		end else if (bvalid && bready) begin
			awready <= 1'b1;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready  <= 1'b1;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else if (wvalid && wready) begin
			wready  <= 1'b0;
			wdata_q <= wdata;
			wstrb_q <= wstrb;
		end else if (bvalid && bready) begin
			wready <= 1'b1;
		end
	end
	assign wr_fire = !awready && !wready && !bvalid;
	assign wr_ep   = aw_addr < `UEFP_EP_SPAN;
	assign wr_idx  = aw_addr[`UEFP_EP_LSB +: 2];
	assign wr_off  = aw_addr[4:0];
	assign wr_desc = aw_addr[11:10] == `UEFP_DESC_SEL;
	assign wr_ok   = wr_desc || (wr_ep && reg_known(wr_off));
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= `UEFP_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			bresp  <= wr_ok ? `UEFP_RESP_OKAY : `UEFP_RESP_DECERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end
	// Read: address taken, one cycle for the descriptor store, then answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rd_pend <= 1'b0;
			rd_addr <= 12'h000;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rd_pend <= 1'b1;
			rd_addr <= araddr;
		end else begin
			rd_pend <= 1'b0;
			if (rvalid && rready) begin
				arready <= 1'b1;
			end
		end
	end
	assign rd_ep   = rd_addr < `UEFP_EP_SPAN;
	assign rd_idx  = rd_addr[`UEFP_EP_LSB +: 2];
	assign rd_off  = rd_addr[4:0];
	assign rd_desc = rd_addr[11:10] == `UEFP_DESC_SEL;
	assign rd_ok   = rd_desc || (rd_ep && reg_known(rd_off));
	always_comb begin
		ep_rdata = 32'h00000000;
		if (rd_off == `UEFP_OFF_RP) begin
			ep_rdata[11:0] = rp[rd_idx];
		end else if (rd_off == `UEFP_OFF_WP) begin
			ep_rdata[11:0] = wp[rd_idx];
		end else if (rd_off == `UEFP_OFF_LFP) begin
			ep_rdata[11:0] = lfp[rd_idx];
		end else if (rd_off == `UEFP_OFF_SIZE) begin
			ep_rdata[3:0] = size[rd_idx];
		end else if (rd_off == `UEFP_OFF_STAT) begin
			ep_rdata[1:0] = {full[rd_idx], empty[rd_idx]};
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h00000000;
			rresp  <= `UEFP_RESP_OKAY;
		end else if (rd_pend) begin
			rvalid <= 1'b1;
			rresp  <= rd_ok ? `UEFP_RESP_OKAY : `UEFP_RESP_DECERR;
			if (rd_desc) begin
				rdata <= desc_rdata;
			end else if (rd_ok) begin
				rdata <= ep_rdata;
			end else begin
				rdata <= 32'h00000000;
			end
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end
	uefp_desc_ram u_desc (
		.aclk    (aclk),
		.aresetn (aresetn),
		.we      (wr_fire && wr_desc),
		.be      (wstrb_q),
		.waddr   (aw_addr[9:2]),
		.wdata   (wdata_q),
		.raddr   ((arvalid && arready) ? araddr[9:2] : rd_addr[9:2]),
		.rdata   (desc_rdata)
	);
	// One FIFO controller per endpoint
	for (genvar n = 0; n < `UEFP_NUM_EP; n++) begin : g_ep
		logic      sw_hit;
		logic      sw_rp;
		logic      sw_wp;
		uefp_ptr_t rp_inc;
		uefp_ptr_t wp_inc;
		assign sw_hit  = wr_fire && wr_ep && (wr_idx == 2'(n));
		assign sw_rp   = sw_hit && (wr_off == `UEFP_OFF_RP);
		assign sw_wp   = sw_hit && (wr_off == `UEFP_OFF_WP);
		assign mask[n] = ~(12'hFFF << size[n]);
		assign rp_inc  = (rp[n] & ~mask[n]) | ((rp[n] + 12'h001) & mask[n]);
		assign wp_inc  = (wp[n] & ~mask[n]) | ((wp[n] + 12'h001) & mask[n]);
		assign empty[n]   = (((rp[n] ^ wp[n]) & mask[n]) == 12'h000) && !full[n];
		assign push_ok[n] = usb_wr_en && (usb_ep == 2'(n)) && !full[n];
		assign pop_ok[n]  = usb_rd_en && (usb_ep == 2'(n)) && !empty[n];
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				rp[n] <= 12'h000;
			end else if (sw_rp) begin
				rp[n] <= (rp[n] & ~mask[n]) | (merge_ptr(rp[n], wdata_q, wstrb_q) & mask[n]);
			end else if (pop_ok[n]) begin
				rp[n] <= rp_inc;
			end
		end
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				wp[n] <= 12'h000;
			end else if (sw_wp) begin
				wp[n] <= (wp[n] & ~mask[n]) | (merge_ptr(wp[n], wdata_q, wstrb_q) & mask[n]);
			end else if (push_ok[n]) begin
				wp[n] <= wp_inc;
			end
		end
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				lfp[n] <= lfp[n] & ~mask[n];
			end else if (sw_hit && (wr_off == `UEFP_OFF_LFP)) begin
				lfp[n] <= (lfp[n] & ~mask[n]) | (merge_ptr(lfp[n], wdata_q, wstrb_q) & mask[n]);
			end else if (push_ok[n] && usb_wr_eof) begin
				lfp[n] <= wp_inc;
			end
		end
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				size[n] <= `UEFP_SIZE_RST;
			end else if (sw_hit && (wr_off == `UEFP_OFF_SIZE) && wstrb_q[0]) begin
				size[n] <= (wdata_q[3:0] > `UEFP_SIZE_MAX) ? `UEFP_SIZE_MAX : wdata_q[3:0];
			end
		end
		// Any software change to the layout drops the full state
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				full[n] <= 1'b0;
			end else if (sw_rp || sw_wp || (sw_hit && (wr_off == `UEFP_OFF_SIZE))) begin
				full[n] <= 1'b0;
			end else if (push_ok[n] && !pop_ok[n]) begin
				full[n] <= ((wp_inc ^ rp[n]) & mask[n]) == 12'h000;
			end else if (pop_ok[n] && !push_ok[n]) begin
				full[n] <= 1'b0;
			end
		end
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ep_empty[n] <= 1'b1;
				ep_full[n]  <= 1'b0;
			end else begin
				ep_empty[n] <= empty[n];
				ep_full[n]  <= full[n];
			end
		end
		property p_rd_advance;
			@(posedge aclk) disable iff (!aresetn)
			pop_ok[n] && !sw_rp |=> (rp[n] & mask[n]) == (($past(rp[n]) + 12'h001) & mask[n]);
		endproperty
		a_rd_advance: assert property (p_rd_advance) else $error("read offset stuck");
		property p_wr_advance;
			@(posedge aclk) disable iff (!aresetn)
			push_ok[n] && !sw_wp |=> (wp[n] & mask[n]) == (($past(wp[n]) + 12'h001) & mask[n]);
		endproperty
		a_wr_advance: assert property (p_wr_advance) else $error("write offset stuck");
		property p_sw_write;
			@(posedge aclk) disable iff (!aresetn)
			sw_rp && wstrb_q[0] && wstrb_q[1] |=> (rp[n] & mask[n]) == ($past(wdata_q[11:0]) & mask[n]);
		endproperty
		a_sw_write: assert property (p_sw_write) else $error("read offset write lost");
		property p_upper_keep;
			@(posedge aclk) disable iff (!aresetn)
			sw_wp |=> (wp[n] & ~mask[n]) == ($past(wp[n]) & ~$past(mask[n]));
		endproperty
		a_upper_keep: assert property (p_upper_keep) else $error("upper offset bits changed");
		property p_wrap;
			@(posedge aclk) disable iff (!aresetn)
			pop_ok[n] && !sw_rp && ((rp[n] & mask[n]) == mask[n]) |=> (rp[n] & mask[n]) == 12'h000;
		endproperty
		a_wrap: assert property (p_wrap) else $error("read offset did not wrap");
		property p_reset_lfp;
			@(posedge aclk) disable iff (!aresetn)
			$rose(aresetn) |-> (lfp[n] & mask[n]) == 12'h000;
		endproperty
		a_reset_lfp: assert property (p_reset_lfp) else $error("frame pointer not cleared");
	end
	// Shared data store, only the addressed endpoint touches it
	assign ram_waddr = ep_base[usb_ep] | (wp[usb_ep] & mask[usb_ep]);
	assign ram_raddr = ep_base[usb_ep] | (rp[usb_ep] & mask[usb_ep]);
	uefp_data_ram u_data (
		.aclk    (aclk),
		.aresetn (aresetn),
		.we      (|push_ok),
		.waddr   (ram_waddr),
		.wdata   (usb_wr_data),
		.raddr   (ram_raddr),
		.rdata   (usb_rd_data)
	);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			usb_rd_valid <= 1'b0;
		end else begin
			usb_rd_valid <= |pop_ok;
		end
	end
	property p_rd_latency;
		@(posedge aclk) disable iff (!aresetn)
		(|pop_ok) |=> usb_rd_valid ##1 !usb_rd_valid || $past(|pop_ok);
	endproperty
	a_rd_latency: assert property (p_rd_latency) else $error("fetch not answered");
	property p_addr_form;
		@(posedge aclk) disable iff (!aresetn)
		(|push_ok) |-> ram_waddr == 12'(ep_base[usb_ep] + (wp[usb_ep] & mask[usb_ep]));
	endproperty
	a_addr_form: assert property (p_addr_form) else $error("bad shared address");
	property p_write_resp;
		@(posedge aclk) disable iff (!aresetn)
		wr_fire |=> bvalid && (bresp == (wr_ok ? 2'h0 : 2'h3)) until_with (bvalid && bready);
	endproperty
	a_write_resp: assert property (p_write_resp) else $error("write answer wrong");
endmodule

// ==== rtl/uefp_cfg.svh ====
`ifndef UEFP_CFG_SVH
`define UEFP_CFG_SVH

// Endpoint count and widths
`define UEFP_NUM_EP      4
`define UEFP_PTR_W       12
`define UEFP_DATA_W      8
`define UEFP_DATA_DEPTH  4096
`define UEFP_AXI_AW      12

// Per-endpoint register block: endpoint index in address bits 6:5
`define UEFP_EP_SPAN     12'h080
`define UEFP_EP_LSB      5
`define UEFP_OFF_RP      5'h00
`define UEFP_OFF_WP      5'h04
`define UEFP_OFF_LFP     5'h08
`define UEFP_OFF_SIZE    5'h0C
`define UEFP_OFF_STAT    5'h10

// Descriptor memory window 0x400..0x7FF, 256 words of 32 bits
`define UEFP_DESC_SEL    2'h1
`define UEFP_DESC_WORDS  256
`define UEFP_DESC_AW     8

// Size field holds log2 of the FIFO depth in bytes
`define UEFP_SIZE_RST    4'h8
`define UEFP_SIZE_MAX    4'hC

`define UEFP_RESP_OKAY   2'h0
`define UEFP_RESP_DECERR 2'h3

`endif

// ==== rtl/uefp_pkg.sv ====
`include "uefp_cfg.svh"

package uefp_pkg;
	typedef logic [`UEFP_PTR_W-1:0]  uefp_ptr_t;
	typedef logic [3:0]              uefp_size_t;
	typedef logic [1:0]              uefp_ep_t;
	typedef logic [`UEFP_DATA_W-1:0] uefp_byte_t;
endpackage

// ==== rtl/uefp_data_ram.sv ====
`timescale 1ns/1ps
`include "uefp_cfg.svh"

// Shared endpoint data store, one write and one registered read port
module uefp_data_ram (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              we,
	input  wire uefp_pkg::uefp_ptr_t  waddr,
	input  wire uefp_pkg::uefp_byte_t wdata,
	input  wire uefp_pkg::uefp_ptr_t  raddr,
	output logic [`UEFP_DATA_W-1:0]   rdata
);
	import uefp_pkg::*;

	uefp_byte_t mem [`UEFP_DATA_DEPTH];

	always_ff @(posedge aclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata <= 8'h00;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule

// ==== rtl/uefp_desc_ram.sv ====
`timescale 1ns/1ps
`include "uefp_cfg.svh"

// Descriptor store, byte-writable words, registered read
module uefp_desc_ram (
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire logic                     we,
	input  wire logic [3:0]               be,
	input  wire logic [`UEFP_DESC_AW-1:0] waddr,
	input  wire logic [31:0]              wdata,
	input  wire logic [`UEFP_DESC_AW-1:0] raddr,
	output logic      [31:0]              rdata
);
	import uefp_pkg::*;

	logic [31:0] mem [`UEFP_DESC_WORDS];

	always_ff @(posedge aclk) begin
		for (int b = 0; b < 4; b++) begin
			if (we && be[b]) begin
				mem[waddr][b*8 +: 8] <= wdata[b*8 +: 8];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata <= 32'h00000000;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule

// ==== dv/uefp_usb_model.sv ====
`timescale 1ns/1ps
// Protocol engine model: one byte request per edge, any endpoint, any order
module uefp_usb_model (
	input  wire logic                 aclk,
	output uefp_pkg::uefp_ep_t        usb_ep,
	output logic                      usb_wr_en,
	output uefp_pkg::uefp_byte_t      usb_wr_data,
	output logic                      usb_wr_eof,
	output logic                      usb_rd_en,
	input  wire uefp_pkg::uefp_byte_t usb_rd_data,
	input  wire logic                 usb_rd_valid
);
	import uefp_pkg::*;
	uefp_byte_t got [$];
	initial begin
		usb_ep = 2'h0;
		usb_wr_en = 1'b0;
		usb_wr_data = 8'hA5;
		usb_wr_eof = 1'b0;
		usb_rd_en = 1'b0;
	end
	// Called just past a rising edge; the request stands for exactly one edge
	task automatic op(input logic w, input logic r, input uefp_ep_t e, input uefp_byte_t d,
		input logic f);
		usb_ep <= e;
		usb_wr_en <= w;
		usb_wr_data <= w ? d : ~usb_wr_data;
		usb_wr_eof <= w & f;
		usb_rd_en <= r;
		@(posedge aclk);
	endtask
	always @(posedge aclk) begin
		if (usb_rd_valid === 1'b1) got.push_back(usb_rd_data);
	end
endmodule

// ==== dv/usb_endpoint_fifo_pointers_bench.sv ====
`timescale 1ns/1ps
`include "uefp_cfg.svh"
module usb_endpoint_fifo_pointers_bench;
	import uefp_pkg::*;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, usb_wr_en, usb_wr_eof, usb_rd_en;
	logic        usb_rd_valid;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v;
	logic [3:0]  wstrb, ep_empty, ep_full;
	logic [1:0]  bresp, rresp;
	uefp_ep_t    usb_ep;
	uefp_byte_t  usb_wr_data, usb_rd_data;
	uefp_ptr_t   ep_base [`UEFP_NUM_EP];
	uefp_byte_t  q [4][$];
	uefp_byte_t  exq [$];
	int          err_total, tests_run, cyc, seed, o, sz [4], wp [4], rp [4], lfp [4];

	uefp_top dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .usb_ep, .usb_wr_en, .usb_wr_data, .usb_wr_eof, .usb_rd_en,
		.usb_rd_data, .usb_rd_valid, .ep_base, .ep_empty, .ep_full);
	uefp_usb_model model_u (.aclk, .usb_ep, .usb_wr_en, .usb_wr_data, .usb_wr_eof,
		.usb_rd_en, .usb_rd_data, .usb_rd_valid);

	initial aclk = 1'b0;
	always #10 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x) begin
			err_total++;
			$display("FAIL %0t word %h expected %h", $time, g, x);
		end
	endtask
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] x);
		tests_run++;
		if (g !== x) begin
			err_total++;
			$display("FAIL %0t byte %h expected %h", $time, g, x);
		end
	endtask
	function automatic logic [11:0] ra(input int n, input int off);
		return 12'(n * 32 + off);
	endfunction
	// Masked pointer update: only the low size bits change
	function automatic int mw(input int p, input int d, input int s);
		return (p & ~((1 << s) - 1)) | (d & ((1 << s) - 1));
	endfunction
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] xr);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				chk_word({30'h0, bresp}, {30'h0, xr});
				bready <= 1'b0;
				break;
			end
		end
		@(posedge aclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [1:0] xr);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				chk_word(rdata, x);
				chk_word({30'h0, rresp}, {30'h0, xr});
				rready <= 1'b0;
				break;
			end
		end
		@(posedge aclk);
	endtask
	task automatic xfer(input logic w, input int n, input uefp_byte_t d, input logic f);
		if (w && q[n].size() < (1 << sz[n])) begin
			q[n].push_back(d);
			wp[n] = mw(wp[n], wp[n] + 1, sz[n]);
			if (f) lfp[n] = wp[n];
		end
		if (!w && q[n].size() > 0) begin
			exq.push_back(q[n].pop_front());
			rp[n] = mw(rp[n], rp[n] + 1, sz[n]);
		end
		model_u.op(w, !w, 2'(n), d, f);
	endtask
	// Empties every FIFO, then compares data, pointers, size and status
	task automatic drain();
		for (int n = 0; n < 4; n++) while (q[n].size() > 0) xfer(1'b0, n, 8'h00, 1'b0);
		model_u.op(1'b0, 1'b0, 2'h0, 8'h00, 1'b0);
		repeat (2) @(posedge aclk);
		chk_word(32'(model_u.got.size()), 32'(exq.size()));
		while (exq.size() > 0 && model_u.got.size() > 0) begin
			chk_byte(model_u.got.pop_front(), exq.pop_front());
		end
		chk_word({24'h0, ep_full, ep_empty}, 32'h0F);
		for (int n = 0; n < 4; n++) begin
			rd(ra(n, 0), 32'(rp[n]), `UEFP_RESP_OKAY);
			rd(ra(n, 4), 32'(wp[n]), `UEFP_RESP_OKAY);
			rd(ra(n, 8), 32'(lfp[n]), `UEFP_RESP_OKAY);
			rd(ra(n, 12), 32'(sz[n]), `UEFP_RESP_OKAY);
			rd(ra(n, 16), 32'h1, `UEFP_RESP_OKAY);
		end
	endtask

	initial begin
		seed = 32;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h0;
		wstrb = 4'h0;
		for (int n = 0; n < 4; n++) begin
			ep_base[n] = 12'(n * 256);
			sz[n] = 8;
		end
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		// Upper frame pointer bits survive reset unknown; open the mask to give them a value
		for (int n = 0; n < 4; n++) begin
			wr(ra(n, 12), 32'hC, 4'hF, `UEFP_RESP_OKAY);
			wr(ra(n, 8), 32'h0, 4'hF, `UEFP_RESP_OKAY);
			wr(ra(n, 12), 32'h8, 4'hF, `UEFP_RESP_OKAY);
		end
		drain();
		repeat (300) begin
			v = $random(seed);
			xfer(v[0], int'(v[2:1]), v[15:8], v[3]);
		end
		drain();
		rd(12'h018, 32'h0, `UEFP_RESP_DECERR);
		wr(12'h800, 32'hFFFFFFFF, 4'hF, `UEFP_RESP_DECERR);
		rd(12'h800, 32'h0, `UEFP_RESP_DECERR);
		wr(ra(2, 16), 32'hFFFFFFFF, 4'hF, `UEFP_RESP_OKAY);
		wr(12'h400, 32'h1234ABCD, 4'hF, `UEFP_RESP_OKAY);
		wr(12'h7FC, 32'hCAFEF00D, 4'hF, `UEFP_RESP_OKAY);
		wr(12'h400, 32'h00005500, 4'h2, `UEFP_RESP_OKAY);
		rd(12'h400, 32'h123455CD, `UEFP_RESP_OKAY);
		rd(12'h7FC, 32'hCAFEF00D, `UEFP_RESP_OKAY);
		wr(ra(0, 12), 32'hF, 4'hF, `UEFP_RESP_OKAY);
		sz[0] = 12;
		wr(ra(1, 12), 32'h4, 4'hF, `UEFP_RESP_OKAY);
		sz[1] = 4;
		wr(ra(1, 0), 32'hFFFFFFFE, 4'hF, `UEFP_RESP_OKAY);
		rp[1] = mw(rp[1], 32'hFFFFFFFE, 4);
		wr(ra(1, 4), 32'hFFFFFFFE, 4'hF, `UEFP_RESP_OKAY);
		wp[1] = mw(wp[1], 32'hFFFFFFFE, 4);
		for (int i = 0; i < 17; i++) xfer(1'b1, 1, 8'(i * 7 + 1), 1'b0);
		model_u.op(1'b0, 1'b0, 2'h0, 8'h00, 1'b0);
		rd(ra(1, 16), 32'h2, `UEFP_RESP_OKAY);
		chk_word({24'h0, ep_full, ep_empty}, 32'h2D);
		for (int i = 0; i < 17; i++) xfer(1'b0, 1, 8'h00, 1'b0);
		drain();
		o = rp[2] & 32'hFF;
		xfer(1'b1, 2, 8'h5A, 1'b1);
		model_u.op(1'b0, 1'b0, 2'h0, 8'h00, 1'b0);
		ep_base[3] <= ep_base[2];
		wr(ra(3, 0), 32'(o), 4'hF, `UEFP_RESP_OKAY);
		rp[3] = mw(rp[3], o, 8);
		wr(ra(3, 4), 32'(o + 1), 4'hF, `UEFP_RESP_OKAY);
		wp[3] = mw(wp[3], o + 1, 8);
		q[3].push_back(8'h5A);
		drain();
		report_and_stop();
	end
endmodule
